// ===== include/eis_consts.vh
`ifndef EIS_CONSTS_VH
`define EIS_CONSTS_VH
// Register indices; the byte address is four times the index.
`define EIS_IDX_CTRL        8'h35
`define EIS_IDX_FLAGS       8'h3a
`define EIS_IDX_REQ_MASK    8'h3b
`define EIS_IDX_IRQ_MASK    8'h3c
`define EIS_IDX_STACK_PTR   8'h3d
`define EIS_IDX_STATUS      8'h3f
// Control register fields.
`define EIS_CTRL_SLEEP_ARM  5
`define EIS_CTRL_SLEEP_KIND 4
`define EIS_CTRL_L1_SENSE   3:2
`define EIS_CTRL_L0_SENSE   1:0
`define EIS_CTRL_WMASK      8'h3f
// Flag and mask fields, shared layout.
`define EIS_F_LINE0         0
`define EIS_F_LINE1         1
`define EIS_F_WAKE          2
`define EIS_STATUS_GIE      7
// Reset values.
`define EIS_RST_CTRL        8'h00
`define EIS_RST_MASK        8'h00
`define EIS_RST_SP          8'h00
// Sense encodings.
`define EIS_SENSE_LOW       2'h0
`define EIS_SENSE_ANY       2'h1
`define EIS_SENSE_FALL      2'h2
`define EIS_SENSE_RISE      2'h3
// Vector addresses.
`define EIS_VEC_RESET       11'h000
`define EIS_VEC_LINE0       11'h001
`define EIS_VEC_LINE1       11'h002
// Timing counts in clock cycles.
`define EIS_ENTRY_CYCLES    4
`define EIS_JUMP_CYCLES     2
`define EIS_TOUT_CYCLES     16'h0400
`endif

// ===== hw/eis_sense.v
`timescale 1ns/1ps
// One request line: samples the pin, then detects level or edges.
module eis_sense
(
   input  wire       clk,
   input  wire       nrst,
   input  wire       pin,
   input  wire [1:0] sense,
   input  wire       edge_en,
   output reg        req_event,
   output wire       level_req
);
`include "eis_consts.vh"
   reg pin_smp;  // Sampled pin.
   reg pin_prev; // Sample one clock earlier.

   // Edges are seen only between two samples, so a pulse must outlast a clock.
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_smp  <= 1'b1;
         pin_prev <= 1'b1;
      end
      else
      begin
         pin_smp  <= pin;
         pin_prev <= pin_smp;
      end
   end

   // Low level request follows the sampled pin directly.
   assign level_req = (sense == `EIS_SENSE_LOW) && !pin_smp;

   // Decode the chosen condition into an event: one cycle for an edge, held for as long as a low level lasts.
   always @*
   begin
      case (sense)
         `EIS_SENSE_LOW:  req_event = level_req;
         `EIS_SENSE_ANY:  req_event = edge_en && (pin_smp != pin_prev);
         `EIS_SENSE_FALL: req_event = edge_en && pin_prev && !pin_smp;
         `EIS_SENSE_RISE: req_event = edge_en && !pin_prev && pin_smp;
         default:         req_event = 1'b0;
      endcase
   end
endmodule

// ===== hw/eis_hold.v
`timescale 1ns/1ps
// Counts how long a condition has held; restarts when it drops.
module eis_hold
#(
   parameter W = 16
)
(
   input  wire         clk,
   input  wire         nrst,
   input  wire         run,
   input  wire [W-1:0] limit,
   output wire         done
);
   reg [W-1:0] cnt; // Cycles the condition has held, saturating.

   // Saturate rather than wrap so a long hold never looks short.
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         cnt <= {W{1'b0}};
      else if (!run)
         cnt <= {W{1'b0}};
      else if (cnt != {W{1'b1}})
         cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
   end

   assign done = run && (cnt >= limit);
endmodule

// ===== hw/eis_top.v
`timescale 1ns/1ps
module eis_top
#(
   parameter [15:0] TOUT_CYCLES = `EIS_TOUT_CYCLES
)
(
   input  wire        CLK,
   input  wire        NRST,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output wire        PREADY,
   output wire        PSLVERR,
   input  wire        EXT_REQ_0,
   input  wire        EXT_REQ_1,
   input  wire        INSN_BOUNDARY,
   input  wire        SLEEP_INSN,
   input  wire        RETURN_DONE,
   input  wire [10:0] PC_IN,
   output wire        CORE_HOLD,
   output reg         VECTOR_GO,
   output reg  [10:0] VECTOR_ADDR,
   output reg         STACK_WE,
   output reg  [7:0]  STACK_ADDR,
   output reg  [7:0]  STACK_WDATA,
   output reg         SLEEPING,
   output reg         POWER_DOWN,
   output wire        IRQ
);
`include "eis_consts.vh"
   // One-hot sequencer states.
   localparam [4:0] S_RUN   = 5'h01;
   localparam [4:0] S_ENTRY = 5'h02;
   localparam [4:0] S_JUMP  = 5'h04;
   localparam [4:0] S_SLEEP = 5'h08;
   localparam [4:0] S_GUARD = 5'h10;
   localparam [2:0] ENTRY_LAST = `EIS_ENTRY_CYCLES - 2;
   localparam [2:0] JUMP_LAST  = `EIS_JUMP_CYCLES - 1;

   reg  [5:0]  ctrl;          // Control register, bits 5..0.
   reg  [1:0]  req_mask;      // Per-line request mask.
   reg  [2:0]  flags;         // Sticky event flags.
   reg  [2:0]  irq_mask;      // Gates flags onto the interrupt pin.
   reg         gie;           // Global interrupt enable.
   reg  [7:0]  sp;            // Stack pointer.
   reg  [4:0]  state;         // Sequencer state.
   reg  [2:0]  cnt;           // Cycle counter inside entry and jump.
   reg  [10:0] ret_pc;        // Return address captured at take.
   reg  [1:0]  svc_line;      // Line being serviced, one-hot.
   reg  [4:0]  next_state;    // Next sequencer state.
   reg  [31:0] rd_mux;        // Read data before registering.
   wire        setup;         // APB setup cycle.
   wire        wr_acc;        // APB write access that completes.
   wire [7:0]  idx;           // Register index from the byte address.
   wire        hit;           // Address maps to a register.
   wire        wr_ctrl;       // Write strobes per register.
   wire        wr_flags;
   wire        wr_rmask;
   wire        wr_imask;
   wire        wr_sp;
   wire        wr_stat;
   wire [1:0]  evt;           // Per-line request events.
   wire [1:0]  lvl;           // Per-line low level requests.
   wire [1:0]  hold_done;     // Low level held past the time-out.
   wire [1:0]  pend;          // Per-line pending requests.
   wire [1:0]  armed;         // Pending, masked in and enabled.
   wire        pd_mode;       // Asleep in power-down.
   wire        take;          // Start an interrupt entry now.
   wire        wake_take;     // Take out of sleep.
   wire        sleep_go;      // Enter sleep now.
   wire [1:0]  pick;          // Chosen line, one-hot.
   wire [1:0]  low_mode;      // Line sensed by low level, not by edges.

   // APB decode: registers sit on aligned words, index times four.
   assign idx      = {2'h0, PADDR[7:2]};
   assign hit      = (PADDR[1:0] == 2'h0) &&
                     (idx == `EIS_IDX_CTRL || idx == `EIS_IDX_FLAGS ||
                      idx == `EIS_IDX_REQ_MASK || idx == `EIS_IDX_IRQ_MASK ||
                      idx == `EIS_IDX_STACK_PTR || idx == `EIS_IDX_STATUS);
   assign setup    = PSEL && !PENABLE;
   assign wr_acc   = PSEL && PENABLE && PWRITE && hit;
   assign wr_ctrl  = wr_acc && (idx == `EIS_IDX_CTRL);
   assign wr_flags = wr_acc && (idx == `EIS_IDX_FLAGS);
   assign wr_rmask = wr_acc && (idx == `EIS_IDX_REQ_MASK);
   assign wr_imask = wr_acc && (idx == `EIS_IDX_IRQ_MASK);
   assign wr_sp    = wr_acc && (idx == `EIS_IDX_STACK_PTR);
   assign wr_stat  = wr_acc && (idx == `EIS_IDX_STATUS);

   // Zero wait states; an unmapped or misaligned address gets an error.
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !hit;

   // Read multiplexer; unused upper bits read as zero.
   always @*
   begin
      rd_mux = 32'h0000_0000;
      case (idx)
         `EIS_IDX_CTRL:      rd_mux = {26'h0, ctrl};
         `EIS_IDX_FLAGS:     rd_mux = {29'h0, flags};
         `EIS_IDX_REQ_MASK:  rd_mux = {30'h0, req_mask};
         `EIS_IDX_IRQ_MASK:  rd_mux = {29'h0, irq_mask};
         `EIS_IDX_STACK_PTR: rd_mux = {24'h0, sp};
         `EIS_IDX_STATUS:    rd_mux = {24'h0, gie, 7'h00};
         default:            rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data is captured in the setup cycle and stands in the access.
   always @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         PRDATA <= 32'h0000_0000;
      else if (setup)
         PRDATA <= hit ? rd_mux : 32'h0000_0000;
   end

   // Software owned configuration. Sleep itself never writes these.
   always @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ctrl     <= 6'h00;
         req_mask <= 2'h0;
         irq_mask <= 3'h0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= PWDATA[5:0];
         if (wr_rmask)
            req_mask <= PWDATA[1:0];
         if (wr_imask)
            irq_mask <= PWDATA[2:0];
      end
   end

   // Power-down stops the edge detectors, like a stopped clock would.
   assign pd_mode = state[3] && POWER_DOWN;

   // Two identical request lines.
   eis_sense u_line0
   (
      .clk       (CLK),
      .nrst      (NRST),
      .pin       (EXT_REQ_0),
      .sense     (ctrl[`EIS_CTRL_L0_SENSE]),
      .edge_en   (!pd_mode),
      .req_event (evt[0]),
      .level_req (lvl[0])
   );

   eis_sense u_line1
   (
      .clk       (CLK),
      .nrst      (NRST),
      .pin       (EXT_REQ_1),
      .sense     (ctrl[`EIS_CTRL_L1_SENSE]),
      .edge_en   (!pd_mode),
      .req_event (evt[1]),
      .level_req (lvl[1])
   );

   // Hold timers qualify a low level before it may leave power-down.
   eis_hold #(.W(16)) u_hold0
   (
      .clk   (CLK),
      .nrst  (NRST),
      .run   (pd_mode && lvl[0] && req_mask[0] && gie),
      .limit (TOUT_CYCLES),
      .done  (hold_done[0])
   );

   eis_hold #(.W(16)) u_hold1
   (
      .clk   (CLK),
      .nrst  (NRST),
      .run   (pd_mode && lvl[1] && req_mask[1] && gie),
      .limit (TOUT_CYCLES),
      .done  (hold_done[1])
   );

   // A level request is live only while the pin stays low, so a source
   // that lets go before the instruction ends may go unserviced.
   assign low_mode = {ctrl[`EIS_CTRL_L1_SENSE] == `EIS_SENSE_LOW,
                      ctrl[`EIS_CTRL_L0_SENSE] == `EIS_SENSE_LOW};
   assign pend  = (flags[1:0] & ~low_mode) | lvl;
   assign armed = pend & req_mask & {2{gie}};
   // Line zero has the lower vector and wins a tie.
   assign pick  = armed[0] ? 2'b01 : {armed[1], 1'b0};

   // Idle wakes on any armed line; power-down only on a held level.
   assign wake_take = state[3] &&
                      (POWER_DOWN ? |(hold_done & armed) : |armed);
   // Entry waits for the running instruction to end.
   assign take      = (state[0] && INSN_BOUNDARY && !RETURN_DONE && |armed) || wake_take;
   assign sleep_go  = state[0] && !take && SLEEP_INSN &&
                      ctrl[`EIS_CTRL_SLEEP_ARM];

   // Sticky flags: an event in the same cycle as a clear wins.
   always @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         flags <= 3'h0;
      else
      begin
         flags <= (flags & ~((wr_flags ? PWDATA[2:0] : 3'h0) |
                             (take ? {1'b0, pick} : 3'h0)))
                  | {wake_take, evt};
      end
   end

   assign IRQ = |(flags & irq_mask);

   // Sequencer next state.
   always @*
   begin
      next_state = state;
      case (state)
         S_RUN:
         begin
            if (take)
               next_state = S_ENTRY;
            else if (sleep_go)
               next_state = S_SLEEP;
            else if (RETURN_DONE)
               next_state = S_GUARD;
         end
         S_ENTRY:
         begin
            if (cnt == ENTRY_LAST)
               next_state = S_JUMP;
         end
         S_JUMP:
         begin
            if (cnt == JUMP_LAST)
               next_state = S_RUN;
         end
         S_SLEEP:
         begin
            if (wake_take)
               next_state = S_ENTRY;
         end
         S_GUARD:
         begin
            // The first finished instruction reopens entry.
            if (INSN_BOUNDARY)
               next_state = S_RUN;
         end
         default:
            next_state = S_RUN;
      endcase
   end

   // Sequencer registers, stack and vector outputs. Reset leaves sleep
   // and points the core at the reset vector.
   always @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         state       <= S_RUN;
         cnt         <= 3'h0;
         ret_pc      <= 11'h000;
         svc_line    <= 2'h0;
         VECTOR_GO   <= 1'b0;
         VECTOR_ADDR <= `EIS_VEC_RESET;
         STACK_WE    <= 1'b0;
         STACK_ADDR  <= 8'h00;
         STACK_WDATA <= 8'h00;
         SLEEPING    <= 1'b0;
         POWER_DOWN  <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         cnt       <= (next_state != state) ? 3'h0 : cnt + 3'h1;
         VECTOR_GO <= 1'b0;
         STACK_WE  <= 1'b0;
         if (take)
         begin
            // In sleep the core parks its PC after the sleep instruction.
            ret_pc   <= PC_IN;
            svc_line <= pick;
            SLEEPING <= 1'b0;
            POWER_DOWN <= 1'b0;
         end
         if (sleep_go)
         begin
            SLEEPING   <= 1'b1;
            POWER_DOWN <= ctrl[`EIS_CTRL_SLEEP_KIND];
         end
         if (state[1] && cnt == 3'h0)
         begin
            STACK_WE    <= 1'b1;
            STACK_ADDR  <= sp;
            STACK_WDATA <= ret_pc[7:0];
         end
         if (state[1] && cnt == 3'h1)
         begin
            STACK_WE    <= 1'b1;
            STACK_ADDR  <= sp;
            STACK_WDATA <= {5'h00, ret_pc[10:8]};
         end
         if (state[1] && cnt == ENTRY_LAST)
         begin
            // Flag set edge plus three entry cycles gives four.
            VECTOR_GO   <= 1'b1;
            VECTOR_ADDR <= svc_line[0] ? `EIS_VEC_LINE0 : `EIS_VEC_LINE1;
         end
      end
   end

   // The core stalls from take until the vector jump is done.
   assign CORE_HOLD = state[1] || state[2] || state[3];

   // Stack pointer and global enable: hardware updates beat software.
   always @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         sp  <= `EIS_RST_SP;
         gie <= 1'b0;
      end
      else
      begin
         if (state[1] && cnt <= 3'h1)
            sp <= sp - 8'h01;
         else if (state[0] && RETURN_DONE)
            sp <= sp + 8'h02;
         else if (wr_sp)
            sp <= PWDATA[7:0];
         if (take)
            gie <= 1'b0;
         else if (state[0] && RETURN_DONE)
            gie <= 1'b1;
         else if (wr_stat)
            gie <= PWDATA[`EIS_STATUS_GIE];
      end
   end
endmodule

// ===== test/eis_assertions.sv
`timescale 1ns/1ps
// Watches the core-facing outputs of the interrupt and sleep block.
module eis_assertions
(
   input wire        CLK,
   input wire        NRST,
   input wire        PSEL,
   input wire        PENABLE,
   input wire        PWRITE,
   input wire [7:0]  PADDR,
   input wire [31:0] PRDATA,
   input wire        INSN_BOUNDARY,
   input wire        SLEEP_INSN,
   input wire        RETURN_DONE,
   input wire        CORE_HOLD,
   input wire        VECTOR_GO,
   input wire        STACK_WE,
   input wire [7:0]  STACK_ADDR,
   input wire        SLEEPING,
   input wire        POWER_DOWN
);
   // One clock domain, so clock and reset are given once for all checks.
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);

   push_before_vector_a: assert property (VECTOR_GO |-> $past(STACK_WE, 1) && $past(STACK_WE, 2))
      else $error("Vector started without two stack pushes.");
   stack_goes_down_a: assert property (STACK_WE && !$past(STACK_WE)
      |=> STACK_WE && STACK_ADDR == $past(STACK_ADDR) - 8'h01) else $error("Bad second push.");
   jump_holds_core_a: assert property (VECTOR_GO |-> CORE_HOLD [*2])
      else $error("Jump from vector shorter than two cycles.");
   take_at_boundary_a: assert property ($rose(CORE_HOLD) |-> $past(INSN_BOUNDARY))
      else $error("Core held outside an instruction boundary.");
   reserved_read_zero_a: assert property (PSEL && PENABLE && !PWRITE && PADDR == 8'hd4
      |-> PRDATA[7:6] == 2'b00) else $error("Reserved control bits read nonzero.");
   sleep_needs_insn_a: assert property ($rose(SLEEPING) |-> $past(SLEEP_INSN))
      else $error("Sleep entered without a sleep instruction.");
   kind_only_asleep_a: assert property (POWER_DOWN |-> SLEEPING)
      else $error("Power-down shown while awake.");
   wake_enters_isr_a: assert property ($fell(SLEEPING) |-> CORE_HOLD)
      else $error("Wake did not go to interrupt entry.");
   no_take_on_return_a: assert property ($rose(CORE_HOLD) |-> !$past(RETURN_DONE))
      else $error("Interrupt taken right at return.");
endmodule

bind eis_top eis_assertions u_chk
(
   .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PRDATA(PRDATA), .INSN_BOUNDARY(INSN_BOUNDARY), .SLEEP_INSN(SLEEP_INSN),
   .RETURN_DONE(RETURN_DONE), .CORE_HOLD(CORE_HOLD), .VECTOR_GO(VECTOR_GO),
   .STACK_WE(STACK_WE), .STACK_ADDR(STACK_ADDR), .SLEEPING(SLEEPING), .POWER_DOWN(POWER_DOWN)
);

// ===== test/eis_pin_model.sv
`timescale 1ns/1ps
// External source behind the two request pins.
module eis_pin_model
(
   input  wire       clk,
   input  wire [1:0] want,
   output reg  [1:0] pin
);
   // Pins idle high, as a pulled-up request line would.
   initial pin = 2'b11;
   // Levels change only on a rising edge and hold for whole cycles, so no pulse is shorter
   // than one clock period and a low level stays until the bench lifts it.
   always @(posedge clk)
   begin
      pin <= want;
   end
endmodule

// ===== test/test_eis_top.sv
`timescale 1ns/1ps
// Plays core and software around the interrupt and sleep block.
module test_eis_top;
   localparam [7:0] A_CTRL = 8'hd4; // Byte address is four times the index.
   localparam [7:0] A_FLG  = 8'he8;
   localparam [7:0] A_RMSK = 8'hec;
   localparam [7:0] A_IMSK = 8'hf0;
   localparam [7:0] A_SP   = 8'hf4;
   localparam [7:0] A_STAT = 8'hfc;
   reg         clk, nrst, psel, penable, pwrite, bnd, slp, ret, err;
   reg  [7:0]  paddr;
   reg  [31:0] pwdata, rd;
   reg  [10:0] pc;
   reg  [1:0]  want;
   reg  [7:0]  stk [0:255]; // Bytes pushed by interrupt entry.
   wire [31:0] prdata;
   wire [10:0] vaddr;
   wire [7:0]  saddr, sdata;
   wire [1:0]  pins;
   wire        pready, pslverr, hold, vgo, swe, sleeping, pdown, irq;
   integer     miscompares, cmp_count, i, m;

   // Short wake time-out keeps the power-down case brief.
   eis_top #(.TOUT_CYCLES(16'h0008)) dut
   (
      .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .EXT_REQ_0(pins[0]), .EXT_REQ_1(pins[1]), .INSN_BOUNDARY(bnd), .SLEEP_INSN(slp),
      .RETURN_DONE(ret), .PC_IN(pc), .CORE_HOLD(hold), .VECTOR_GO(vgo), .VECTOR_ADDR(vaddr),
      .STACK_WE(swe), .STACK_ADDR(saddr), .STACK_WDATA(sdata), .SLEEPING(sleeping),
      .POWER_DOWN(pdown), .IRQ(irq)
   );
   eis_pin_model u_pins (.clk(clk), .want(want), .pin(pins));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Keeps what entry pushes so the byte order can be checked later.
   always @(posedge clk)
   begin
      if (swe)
         stk[saddr] <= sdata;
   end

   task check(input [31:0] seen, input [31:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   end
   endtask

   task cyc(input integer k);
      repeat (k) @(posedge clk);
   endtask

   // One APB transfer; the idle edge first keeps back-to-back calls from clashing.
   task apb(input wr, input [7:0] a, input [31:0] d);
   begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask

   task wr(input [7:0] a, input [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdc(input [7:0] a, input [31:0] exp);
   begin
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   end
   endtask

   // Waits for the vector pulse, checks where it points, ends on a rising edge.
   task wait_go(input [10:0] exp);
      integer n;
   begin
      n = 0;
      do
      begin
         @(negedge clk);
         n = n + 1;
      end
      while (vgo !== 1'b1 && n < 60);
      check(vgo, 1);
      check(vaddr, exp);
      @(posedge clk);
   end
   endtask

   // Return from a handler at a boundary; the first boundary after it must not take.
   task ret_pulse;
   begin
      bnd <= 1'b1;
      cyc(2);
      ret <= 1'b1;
      cyc(1);
      ret <= 1'b0;
      cyc(1);
      @(negedge clk);
      check(hold, 0);
      cyc(3);
   end
   endtask

   task end_sim;
   begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask

   initial
   begin
      #200000;
      miscompares = miscompares + 1;
      end_sim;
   end

   initial
   begin
      miscompares = 0;
      cmp_count = 0;
      {nrst, psel, penable, pwrite, bnd, slp, ret} = 7'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pc = 11'h123;
      want = 2'b11;
      cyc(8);
      nrst <= 1'b1;
      @(negedge clk);
      check(vaddr, 0);
      rdc(A_CTRL, 32'h0);
      rdc(A_FLG, 32'h0);
      wr(A_CTRL, 32'hff);
      rdc(A_CTRL, 32'h3f);
      apb(1'b0, 8'h00, 32'h0);
      check(err, 1);
      wr(A_IMSK, 32'h3);
      wr(A_STAT, 32'h80);
      wr(A_SP, 32'h80);
      // Every edge sense on both lines; boundary low so nothing is taken.
      for (i = 0; i < 2; i = i + 1)
         for (m = 1; m < 4; m = m + 1)
         begin
            wr(A_CTRL, m << (2 * i));
            want[i] <= 1'b0;
            cyc(4);
            rdc(A_FLG, (m != 3) << i);
            check(irq, m != 3);
            wr(A_FLG, 32'h3);
            want[i] <= 1'b1;
            cyc(4);
            rdc(A_FLG, (m != 2) << i);
            wr(A_FLG, 32'h3);
         end
      // Interrupt line masking, then a line without its request mask bit.
      wr(A_CTRL, 32'h02);
      wr(A_IMSK, 32'h0);
      want[0] <= 1'b0;
      cyc(4);
      check(irq, 0);
      wr(A_IMSK, 32'h3);
      @(negedge clk);
      check(irq, 1);
      wr(A_FLG, 32'h1);
      @(negedge clk);
      check(irq, 0);
      @(posedge clk);
      want[0] <= 1'b1;
      bnd <= 1'b1;
      cyc(3);
      want[0] <= 1'b0;
      cyc(8);
      check(hold, 0);
      rdc(A_FLG, 32'h1);
      // Both lines at once, first mid-instruction, then at a boundary.
      bnd <= 1'b0;
      want <= 2'b11;
      cyc(3);
      wr(A_FLG, 32'h3);
      wr(A_CTRL, 32'h0a);
      wr(A_RMSK, 32'h3);
      want <= 2'b00;
      cyc(6);
      check(hold, 0);
      bnd <= 1'b1;
      wait_go(11'h001);
      check(stk[8'h80], 8'h23);
      check(stk[8'h7f], 8'h01);
      rdc(A_SP, 32'h7e);
      ret_pulse;
      wait_go(11'h002);
      rdc(A_SP, 32'h7e);
      // Sleep refused without arm, then idle sleep woken by a pin change.
      want <= 2'b11;
      ret_pulse;
      wr(A_FLG, 32'h7);
      wr(A_CTRL, 32'h01);
      slp <= 1'b1;
      cyc(1);
      slp <= 1'b0;
      cyc(2);
      check(sleeping, 0);
      wr(A_CTRL, 32'h21);
      slp <= 1'b1;
      cyc(1);
      slp <= 1'b0;
      cyc(2);
      check(sleeping, 1);
      check(pdown, 0);
      want[0] <= 1'b0;
      wait_go(11'h001);
      rdc(A_FLG, 32'h4);
      rdc(A_CTRL, 32'h21);
      // Power-down: a short low level is ignored, a long one wakes.
      bnd <= 1'b0;
      want[0] <= 1'b1;
      cyc(4);
      wr(A_FLG, 32'h7);
      wr(A_CTRL, 32'h30);
      ret_pulse;
      slp <= 1'b1;
      cyc(1);
      slp <= 1'b0;
      cyc(2);
      check(pdown, 1);
      want[0] <= 1'b0;
      cyc(3);
      want[0] <= 1'b1;
      cyc(12);
      check(sleeping, 1);
      want[0] <= 1'b0;
      wait_go(11'h001);
      want[0] <= 1'b1;
      // Reset while asleep restarts at the reset vector.
      ret_pulse;
      slp <= 1'b1;
      cyc(1);
      slp <= 1'b0;
      cyc(2);
      check(sleeping, 1);
      nrst <= 1'b0;
      cyc(2);
      nrst <= 1'b1;
      @(negedge clk);
      check(sleeping, 0);
      check(vaddr, 0);
      rdc(A_CTRL, 32'h0);
      end_sim;
   end
endmodule
